// ===== hdl/uss_regs.svh
// Register offsets, field positions and reset values of the serial block
`ifndef USS_REGS_SVH
`define USS_REGS_SVH
`define USS_ADDR_W 8
`define USS_CTRL_IDX 6'h0D
`define USS_STAT_IDX 6'h0E
`define USS_PINS_IDX 6'h0F
`define USS_SHIFT_IDX 6'h10
`define USS_RST_BYTE 8'h00
`define USS_ST_SIF 7
`define USS_ST_OIF 6
`define USS_ST_PF 5
`define USS_CR_CLK 1
`define USS_CR_TC 0
`define USS_WM_OFF 2'h0
`define USS_WM_THREE 2'h1
`define USS_WM_HOLD 2'h3
`define USS_CS_SOFT 2'h0
`define USS_CS_TIMER 2'h1
`define USS_RESP_OK 2'h0
`define USS_RESP_ERR 2'h2
`endif

// ===== hdl/uss_pkg.sv
// Types shared by the serial status and control block
`default_nettype none
package uss_pkg;
  // Control register fields as held in the block
  typedef struct packed {
    logic sie;
    logic oie;
    logic [1:0] wm;
    logic [1:0] cs;
    logic strobeSel;
  } uss_ctrl_t;
  // Drive of the three serial pins and their pull-ups
  typedef struct packed {
    logic sdaOe;
    logic sdaOut;
    logic sclOe;
    logic sclOut;
    logic doOe;
    logic doOut;
    logic pullData;
    logic pullClk;
  } uss_pin_t;
endpackage : uss_pkg
`default_nettype wire

// ===== hdl/uss_sync.sv
// Two-stage synchroniser for pin levels, one chain per bit
`default_nettype none
module uss_sync #(
  parameter int WIDTH = 2,
  parameter int STAGES = 2
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  if (STAGES < 2) begin : g_check
    $error("uss_sync needs at least two stages");
  end
  // Only the last stage is visible outside; reset to the idle high level
  // of the pulled-up lines so no false edge follows reset
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    logic [STAGES-1:0] chain_r;
    always_ff @(posedge ref_clk) begin
      if (sys_rst) chain_r <= '1;
      else chain_r <= {chain_r[STAGES-2:0], din[b]};
    end
    assign dout[b] = chain_r[STAGES-1];
  end
endmodule : uss_sync
`default_nettype wire

// ===== hdl/uss_counter.sv
// Transfer counter with direct load and wrap pulse
`default_nettype none
module uss_counter #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadVal,
  output logic [WIDTH-1:0] count,
  output logic wrap
);
  if (WIDTH < 1 || WIDTH > 8) begin : g_check
    $error("uss_counter width must be 1 to 8");
  end
  logic [WIDTH-1:0] count_r;
  // Software load wins over a clock in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) count_r <= '0;
    else if (load) count_r <= loadVal;
    else if (tick) count_r <= count_r + 1'b1;
  end
  assign count = count_r;
  assign wrap = tick && !load && (&count_r);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence seqStep;
    tick && !load ##0 !(&count_r);
  endsequence
  a_cnt_step: assert property (seqStep |=> count_r == $past(count_r) + 1'b1)
    else $error("counter did not step by one");
  a_cnt_wrap: assert property (wrap |=> count_r == '0)
    else $error("counter did not wrap to zero");
endmodule : uss_counter
`default_nettype wire

// ===== hdl/uss_top.sv
// Serial interface status and control with AXI4-Lite register access
`include "uss_regs.svh"
`default_nettype none
module uss_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [`USS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`USS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic tmrMatch,
  input wire logic sleepIdle,
  output uss_pkg::uss_pin_t pinDrive,
  output logic startIrq,
  output logic ovfIrq,
  output logic wakeReq
);
  import uss_pkg::*;

  localparam logic [`USS_ADDR_W-1:0] CTRL_ADDR = {`USS_CTRL_IDX, 2'b00};
  localparam logic [`USS_ADDR_W-1:0] STAT_ADDR = {`USS_STAT_IDX, 2'b00};
  localparam logic [`USS_ADDR_W-1:0] PINS_ADDR = {`USS_PINS_IDX, 2'b00};
  localparam logic [`USS_ADDR_W-1:0] SHIFT_ADDR = {`USS_SHIFT_IDX, 2'b00};

  uss_ctrl_t ctrl_r;
  uss_pin_t pinDrive_r;
  uss_pin_t pinNxt;
  logic awReady_r, wReady_r, bValid_r, arReady_r, rValid_r;
  logic [1:0] bResp_r, rResp_r;
  logic [31:0] rData_r;
  logic startFlag_r, ovfFlag_r, stopFlag_r;
  logic startArmed_r, startHold_r, ovfHold_r;
  logic portClk_r, portData_r, dirClk_r, dirData_r, gie_r;
  logic [7:0] shift_r;
  logic sclPrev_r, sdaPrev_r;
  logic startIrq_r, ovfIrq_r, wakeReq_r;
  logic sclS, sdaS;
  logic [3:0] cnt;
  logic cntWrap;

  // Pins come from the partner's domain: two flops before use
  uss_sync #(.WIDTH(2), .STAGES(2)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .din({sclIn, sdaIn}),
    .dout({sclS, sdaS})
  );

  // Edge and bus condition detection on synchronised levels
  wire sclRise = sclS && !sclPrev_r;
  wire sclFall = !sclS && sclPrev_r;
  wire sclEdge = sclRise || sclFall;
  wire sclHigh = sclS && sclPrev_r;
  wire startDet = sclHigh && sdaPrev_r && !sdaS;
  wire stopDet = sclHigh && !sdaPrev_r && sdaS;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= sclS;
      sdaPrev_r <= sdaS;
    end
  end

  // Register bus decode; data sits in the low byte lane
  wire wrFire = s_axi_awvalid && awReady_r && s_axi_wvalid && wReady_r;
  wire wrEn = wrFire && s_axi_wstrb[0];
  wire [7:0] wrByte = s_axi_wdata[7:0];
  wire wrCtrl = wrEn && (s_axi_awaddr == CTRL_ADDR);
  wire wrStat = wrEn && (s_axi_awaddr == STAT_ADDR);
  wire wrPins = wrEn && (s_axi_awaddr == PINS_ADDR);
  wire wrShift = wrEn && (s_axi_awaddr == SHIFT_ADDR);
  wire wrMapped = (s_axi_awaddr == CTRL_ADDR) ||
    (s_axi_awaddr == STAT_ADDR) || (s_axi_awaddr == PINS_ADDR) ||
    (s_axi_awaddr == SHIFT_ADDR);
  wire rdFire = s_axi_arvalid && arReady_r;

  // Write-one-to-clear strobes for the three flags
  wire clrStart = wrStat && wrByte[`USS_ST_SIF];
  wire clrOvf = wrStat && wrByte[`USS_ST_OIF];
  wire clrStop = wrStat && wrByte[`USS_ST_PF];

  // Mode and clock source decode
  wire twoWire = ctrl_r.wm[1];
  wire extSrc = ctrl_r.cs[1];
  wire swStrobe = wrCtrl && wrByte[`USS_CR_CLK] &&
    (wrByte[3:2] == `USS_CS_SOFT);
  wire tcStrobe = wrCtrl && wrByte[`USS_CR_TC];
  wire extShift = ctrl_r.cs[0] ? sclFall : sclRise;

  // Counter clock: external edges even with outputs off
  wire cntTick = (ctrl_r.cs == `USS_CS_SOFT) ? swStrobe :
    (ctrl_r.cs == `USS_CS_TIMER) ? tmrMatch :
    ctrl_r.strobeSel ? tcStrobe :
    sclEdge;
  wire shiftTick = (ctrl_r.cs == `USS_CS_SOFT) ? swStrobe :
    (ctrl_r.cs == `USS_CS_TIMER) ? tmrMatch : extShift;

  uss_counter #(.WIDTH(4)) u_cnt (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .tick(cntTick),
    .load(wrStat),
    .loadVal(wrByte[3:0]),
    .count(cnt),
    .wrap(cntWrap)
  );

  // Flag sources; start detector only runs in two-wire modes
  wire setStart = (twoWire && startDet) ||
    (!twoWire && extSrc && !ctrl_r.strobeSel && sclEdge);
  wire setStop = twoWire && stopDet;
  wire collision = shift_r[7] != sdaS;

  // Status read image
  wire [7:0] statByte = {startFlag_r, ovfFlag_r, stopFlag_r, collision,
    cnt};
  wire [7:0] ctrlByte = {ctrl_r.sie, ctrl_r.oie, ctrl_r.wm, ctrl_r.cs,
    2'b00};
  wire [7:0] pinsByte = {3'h0, gie_r, dirData_r, dirClk_r, portData_r,
    portClk_r};
  wire rdMapped = (s_axi_araddr == CTRL_ADDR) ||
    (s_axi_araddr == STAT_ADDR) || (s_axi_araddr == PINS_ADDR) ||
    (s_axi_araddr == SHIFT_ADDR);
  wire [7:0] rdByte = (s_axi_araddr == CTRL_ADDR) ? ctrlByte :
    (s_axi_araddr == STAT_ADDR) ? statByte :
    (s_axi_araddr == PINS_ADDR) ? pinsByte :
    (s_axi_araddr == SHIFT_ADDR) ? shift_r : 8'h00;

  // Write channel: both halves are taken in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      awReady_r <= 1'b0;
      wReady_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= `USS_RESP_OK;
    end else begin
      awReady_r <= !awReady_r && !bValid_r && s_axi_awvalid &&
        s_axi_wvalid;
      wReady_r <= !wReady_r && !bValid_r && s_axi_awvalid && s_axi_wvalid;
      if (wrFire) begin
        bValid_r <= 1'b1;
        bResp_r <= wrMapped ? `USS_RESP_OK : `USS_RESP_ERR;
      end else if (s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // Read channel: one read under way, data captured at acceptance
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      arReady_r <= 1'b0;
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= `USS_RESP_OK;
    end else begin
      arReady_r <= !arReady_r && !rValid_r && s_axi_arvalid;
      if (rdFire) begin
        rValid_r <= 1'b1;
        rData_r <= {24'h000000, rdByte};
        rResp_r <= rdMapped ? `USS_RESP_OK : `USS_RESP_ERR;
      end else if (s_axi_rready) begin
        rValid_r <= 1'b0;
      end
    end
  end

  // Control and pin-port registers; the TC strobe bit is not stored, the CLK bit is kept as strobeSel
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r <= uss_ctrl_t'(7'h00);
      {gie_r, dirData_r, dirClk_r, portData_r} <= 4'h0;
    end else begin
      if (wrCtrl) ctrl_r <= uss_ctrl_t'(wrByte[7:1]);
      if (wrPins) {gie_r, dirData_r, dirClk_r, portData_r} <= wrByte[4:1];
    end
  end

  // Clock port bit: toggle works whatever the direction
  always_ff @(posedge ref_clk) begin
    if (sys_rst) portClk_r <= 1'b0;
    else if (tcStrobe) portClk_r <= !portClk_r;
    else if (wrPins) portClk_r <= wrByte[0];
  end

  // Shift register; a direct write beats a shift clock
  always_ff @(posedge ref_clk) begin
    if (sys_rst) shift_r <= `USS_RST_BYTE;
    else if (wrShift) shift_r <= wrByte;
    else if (shiftTick) shift_r <= {shift_r[6:0], sdaS};
  end

  // Flags: a set in the clearing cycle survives
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      startFlag_r <= 1'b0;
      ovfFlag_r <= 1'b0;
      stopFlag_r <= 1'b0;
    end else begin
      startFlag_r <= setStart || (startFlag_r && !clrStart);
      ovfFlag_r <= cntWrap || (ovfFlag_r && !clrOvf);
      stopFlag_r <= setStop || (stopFlag_r && !clrStop);
    end
  end

  // Clock holds; mode zero drops every hold at once
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !twoWire) begin
      startArmed_r <= 1'b0;
      startHold_r <= 1'b0;
      ovfHold_r <= 1'b0;
    end else begin
      if (startDet) startArmed_r <= 1'b1;
      else if (sclFall || clrStart) startArmed_r <= 1'b0;
      if (startArmed_r && sclFall) startHold_r <= 1'b1;
      else if (clrStart) startHold_r <= 1'b0;
      if (ctrl_r.wm == `USS_WM_HOLD && cntWrap) ovfHold_r <= 1'b1;
      else if (clrOvf) ovfHold_r <= 1'b0;
    end
  end

  // Pin drive: two-wire lines are open-collector, low or released
  wire sdaLow = !shift_r[7] || !portData_r;
  wire sclLow = !portClk_r || startHold_r || ovfHold_r;
  always_comb begin
    pinNxt.sdaOe = twoWire && dirData_r && sdaLow;
    pinNxt.sdaOut = 1'b0;
    pinNxt.sclOe = twoWire ? (dirClk_r && sclLow) : dirClk_r;
    pinNxt.sclOut = twoWire ? 1'b0 : portClk_r;
    pinNxt.doOe = !twoWire && dirData_r;
    pinNxt.doOut = (ctrl_r.wm == `USS_WM_THREE) ? shift_r[7] :
      portData_r;
    pinNxt.pullData = !twoWire && !dirData_r && portData_r;
    pinNxt.pullClk = !twoWire && !dirClk_r && portClk_r;
  end

  // Interrupt levels follow flags and enables with no extra latch
  wire startIrqNxt = startFlag_r && ctrl_r.sie && gie_r;
  wire ovfIrqNxt = ovfFlag_r && ctrl_r.oie && gie_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pinDrive_r <= uss_pin_t'(8'h00);
      startIrq_r <= 1'b0;
      ovfIrq_r <= 1'b0;
      wakeReq_r <= 1'b0;
    end else begin
      pinDrive_r <= pinNxt;
      startIrq_r <= startIrqNxt;
      ovfIrq_r <= ovfIrqNxt;
      wakeReq_r <= startIrqNxt || (ovfIrqNxt && sleepIdle);
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign pinDrive = pinDrive_r;
  assign startIrq = startIrq_r;
  assign ovfIrq = ovfIrq_r;
  assign wakeReq = wakeReq_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence seqStartThenFall;
    twoWire && startArmed_r && sclFall && dirClk_r ##1 twoWire;
  endsequence

  a_start_set: assert property (twoWire && startDet |=> startFlag_r)
    else $error("start condition not flagged");
  a_edge_start: assert property (
    !twoWire && extSrc && !ctrl_r.strobeSel && sclEdge |=> startFlag_r)
    else $error("clock edge did not set start flag");
  a_irq_start: assert property (
    startFlag_r && ctrl_r.sie && gie_r |=> startIrq_r ##0 wakeReq_r)
    else $error("start interrupt or wake missing");
  a_start_keep: assert property (
    startFlag_r && !clrStart |=> startFlag_r)
    else $error("start flag cleared without a write");
  a_ovf_set: assert property (cntWrap |=> ovfFlag_r)
    else $error("overflow not flagged on wrap");
  a_wake_idle: assert property (
    !startIrqNxt && !sleepIdle |=> !wakeReq_r)
    else $error("overflow woke from deep sleep");
  a_stop_flag: assert property (twoWire && stopDet |=> stopFlag_r)
    else $error("stop condition not flagged");
  a_sda_low: assert property (
    twoWire && dirData_r && !shift_r[7] |=> pinDrive_r.sdaOe)
    else $error("two-wire data not pulled low");
  a_scl_hold: assert property (
    seqStartThenFall |=> pinDrive_r.sclOe && !pinDrive_r.sclOut)
    else $error("start hold did not pull clock low");
  a_ovf_hold: assert property (
    ctrl_r.wm == `USS_WM_HOLD && cntWrap ##1 !clrOvf && dirClk_r &&
    twoWire |=> pinDrive_r.sclOe)
    else $error("overflow hold not applied");
  a_mode_off: assert property (
    ctrl_r.wm == `USS_WM_OFF |=> !startHold_r && !ovfHold_r)
    else $error("hold active with outputs off");
  a_pull_off: assert property (
    twoWire |=> !pinDrive_r.pullData && !pinDrive_r.pullClk)
    else $error("pull-up left on in two-wire mode");
endmodule : uss_top
`default_nettype wire

// ===== tb/uss_peer.sv
// Two-wire peer master: open-drain clock and data with pull-ups
`default_nettype none
module uss_peer (
  input wire logic sclLine,
  output logic sclDrv,
  output logic sdaDrv
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 100;
  int w;
  // Both lines released at start; pull-ups make them high
  initial begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  // Release clock and honour any hold from the far end, bounded
  task automatic rel_scl;
    sclDrv = 1'b1;
    w = 0;
    while (sclLine !== 1'b1 && w < 4000) begin
      #25;
      w++;
    end
    #HALF;
  endtask : rel_scl
  // Data falls while clock is high
  task automatic start_c;
    #5; // Off the system clock edge, so the synchroniser never races
    sdaDrv = 1'b0;
    #HALF;
  endtask : start_c
  // Falling then rising clock; data only moves while clock is low
  task automatic bit_c(input logic b);
    #5; // Off the system clock edge, so the synchroniser never races
    sclDrv = 1'b0;
    #HALF;
    sdaDrv = b;
    rel_scl();
  endtask : bit_c
  // Data rises while clock is high
  task automatic stop_c;
    bit_c(1'b0);
    sdaDrv = 1'b1;
    #HALF;
  endtask : stop_c
endmodule : uss_peer
`default_nettype wire

// ===== tb/universal_serial_status_control_tb.sv
// Self-checking bench for the serial status and control block
`include "uss_regs.svh"
`default_nettype none
module universal_serial_status_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import uss_pkg::*;
  localparam logic [7:0] CTRL = {`USS_CTRL_IDX, 2'b00};
  localparam logic [7:0] STAT = {`USS_STAT_IDX, 2'b00};
  localparam logic [7:0] PINS = {`USS_PINS_IDX, 2'b00};
  localparam logic [7:0] SHIFT = {`USS_SHIFT_IDX, 2'b00};
  localparam logic [7:0] UNM = 8'h44;
  logic refClk, sysRst, awValid, wValid, bReady, arValid, rReady;
  logic awReady, wReady, bValid, arReady, rValid;
  logic tmrMatch, sleepIdle, startIrq, ovfIrq, wakeReq, sclDrv, sdaDrv;
  logic [7:0] awAddr, arAddr, mSh;
  logic [31:0] wData, rData, got;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp, resp;
  wire logic sclLine, sdaLine;
  uss_pin_t pinDrive;
  int n_errors, samples_checked, seed, mCnt, mSt, i, n;
  // Wired AND: a released or unselected line sits at its pull-up
  assign sclLine = (pinDrive.sclOe ? pinDrive.sclOut : 1'b1) & sclDrv;
  assign sdaLine = (pinDrive.sdaOe ? pinDrive.sdaOut : 1'b1) & sdaDrv;
  uss_top DUT (.ref_clk(refClk), .sys_rst(sysRst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .sclIn(sclLine), .sdaIn(sdaLine),
    .tmrMatch(tmrMatch), .sleepIdle(sleepIdle), .pinDrive(pinDrive),
    .startIrq(startIrq), .ovfIrq(ovfIrq), .wakeReq(wakeReq));
  uss_peer peer (.sclLine(sclLine), .sclDrv(sclDrv), .sdaDrv(sdaDrv));
  // 40 MHz system clock
  initial begin
    refClk = 1'b0;
    forever #12.5 refClk = ~refClk;
  end
  // Model status word: flags, collision, counter
  function automatic logic [31:0] st(input int c);
    return 32'(mSt + c * 16 + mCnt % 16);
  endfunction : st
  // Write: each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge refClk);
    awAddr <= a;
    wData <= {24'h000000, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge refClk);
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
    resp = bResp;
  endtask : wr
  // Read: data and response taken at the edge with rvalid high
  task automatic rd(input logic [7:0] a);
    @(posedge refClk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge refClk);
      if (arReady === 1'b1) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
    got = rData;
    resp = rResp;
  endtask : rd
  // Signal compare
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Register compare, data and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
    rd(a);
    chk(got, e);
    chk({30'h0, resp}, {30'h0, r});
  endtask : rdc
  task automatic wt(input int k);
    repeat (k) @(posedge refClk);
  endtask : wt
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  // Watchdog sized well beyond the whole sequence
  initial begin
    #400000;
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude();
  end
  // Main sequence
  initial begin
    {awValid, wValid, bReady, arValid, rReady, tmrMatch} = '0;
    {awAddr, arAddr, wData, sleepIdle, mSh} = '0;
    wStrb = 4'hF;
    sysRst = 1'b1;
    {n_errors, samples_checked, mCnt, mSt} = '0;
    seed = 48;
    wt(2);
    sysRst <= 1'b0;
    wt(1);
    chk(32'(pinDrive), 32'h0);
    peer.start_c();
    peer.stop_c();
    wt(4);
    rdc(CTRL, 32'h0, `USS_RESP_OK);
    rdc(STAT, st(!mSh[7]), `USS_RESP_OK);
    wr(UNM, 8'hFF);
    chk({30'h0, resp}, {30'h0, `USS_RESP_ERR});
    rdc(UNM, 32'h0, `USS_RESP_ERR);
    // Low byte lane off: the write is answered but changes nothing
    wStrb <= 4'hE;
    wr(CTRL, 8'hFF);
    wStrb <= 4'hF;
    chk({30'h0, resp}, {30'h0, `USS_RESP_OK});
    rdc(CTRL, 32'h0, `USS_RESP_OK);
    $display("reset and map test done");
    wr(STAT, 8'h0E);
    mCnt = 14;
    rdc(STAT, st(!mSh[7]), `USS_RESP_OK);
    for (i = 0; i < 2; i++) begin
      wr(CTRL, 8'h02);
      mCnt++;
      mSh = {mSh[6:0], 1'b1}; // Data line rests at its pull-up
      rdc(STAT, st(!mSh[7]) + (mCnt == 16 ? 32'h40 : 32'h0),
          `USS_RESP_OK);
    end
    mSt = 'h40;
    mCnt = 0;
    rdc(STAT, st(!mSh[7]), `USS_RESP_OK);
    wr(PINS, 8'h10);
    wr(CTRL, 8'h40);
    wt(2);
    chk({ovfIrq, wakeReq}, 2'b10);
    sleepIdle <= 1'b1;
    wt(2);
    chk({ovfIrq, wakeReq}, 2'b11);
    wr(STAT, 8'h40);
    mSt = 0;
    wt(2);
    chk({ovfIrq, wakeReq}, 2'b00);
    sleepIdle <= 1'b0;
    $display("strobe and overflow test done");
    wr(CTRL, 8'h04);
    n = 1 + {$random(seed)} % 20;
    repeat (n) begin
      @(posedge refClk);
      tmrMatch <= 1'b1;
      @(posedge refClk);
      tmrMatch <= 1'b0;
      mSh = {mSh[6:0], 1'b1};
    end
    mCnt = n;
    mSt = n > 15 ? 'h40 : 0;
    rdc(STAT, st(!mSh[7]), `USS_RESP_OK);
    rdc(SHIFT, {24'h000000, mSh}, `USS_RESP_OK);
    wr(STAT, 8'hE0);
    {mSt, mCnt} = '0;
    wr(CTRL, 8'h0A);
    for (i = 1; i < 3; i++) begin
      wr(CTRL, 8'h0B);
      mCnt++;
      rdc(PINS, 32'h10 + i % 2, `USS_RESP_OK);
      rdc(STAT, st(!mSh[7]), `USS_RESP_OK);
    end
    $display("timer and toggle test done");
    for (i = 0; i < 2; i++) begin
      wr(CTRL, i ? 8'h1C : 8'h08);
      wr(STAT, 8'hE0);
      peer.bit_c(1'b1);
      wt(6);
      mCnt = 2;
      mSt = 'h80;
      mSh = {mSh[6:0], 1'b1}; // One shift edge per bit, both modes
      rdc(STAT, st(!mSh[7]), `USS_RESP_OK);
      rdc(SHIFT, {24'h000000, mSh}, `USS_RESP_OK);
    end
    wr(PINS, 8'h18);
    wr(SHIFT, 8'h80);
    wt(2);
    chk({pinDrive.doOe, pinDrive.doOut, pinDrive.sdaOe}, 3'b110);
    $display("external clock test done");
    wr(CTRL, 8'hA0);
    wr(PINS, 8'h1F);
    wr(SHIFT, 8'hFF);
    wr(STAT, 8'hE0);
    {mSt, mCnt} = '0;
    rdc(STAT, st(0), `USS_RESP_OK);
    chk(32'(pinDrive) & 32'hA3, 32'h0);
    peer.start_c();
    wt(4);
    mSt = 'h80;
    chk({startIrq, wakeReq, pinDrive.sclOe}, 3'b110);
    rdc(STAT, st(1), `USS_RESP_OK);
    fork
      peer.bit_c(1'b1);
      begin
        n = 0;
        while (pinDrive.sclOe !== 1'b1 && n < 40) begin
          @(posedge refClk);
          n++;
        end
        chk({pinDrive.sclOe, pinDrive.sclOut}, 2'b10);
        wt(20);
        chk(sclLine, 1'b0);
        wr(STAT, 8'h80);
        mSt = 0;
        wt(2);
        chk(pinDrive.sclOe, 1'b0);
      end
    join
    $display("start hold test done");
    wr(CTRL, 8'h30);
    wr(STAT, 8'h0F);
    wr(CTRL, 8'h32);
    wt(2);
    chk(pinDrive.sclOe, 1'b1);
    wr(STAT, 8'h40);
    wt(2);
    chk(pinDrive.sclOe, 1'b0);
    wr(SHIFT, 8'hFF);
    peer.stop_c();
    wt(4);
    {mSt, mCnt} = {32'h20, 32'h0};
    rdc(STAT, st(0), `USS_RESP_OK);
    chk({startIrq, ovfIrq}, 2'b00);
    $display("overflow hold and stop test done");
    conclude();
  end
endmodule : universal_serial_status_control_tb
`default_nettype wire
